// >>> bench/host_bus_monitor.sv
// Concurrent checks on the ports of the host bus front end.
`timescale 1ns/100ps
module host_bus_monitor #(
    parameter int PORT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration
    input wire logic data_width_select,
    input wire logic reset_polarity_select,
    input wire logic [PORT_W-1:0] port_b_function_map,
    input wire logic [PORT_W-1:0] port_b_driver_style,
    input wire logic [2:0] port_c_function_map,
    // Pins and decoder outputs
    input wire logic host_reset_pin,
    input wire logic [PORT_W-1:0] port_a_oe,
    input wire logic [PORT_W-1:0] port_b_out,
    input wire logic [PORT_W-1:0] port_b_oe,
    input wire logic [2:0] port_c_out,
    input wire logic [2:0] port_c_oe,
    input wire logic aux_select_eight,
    input wire logic aux_select_nine,
    input wire logic host_memory_ready,
    // Internal side
    input wire logic device_reset,
    input wire logic int_read,
    input wire logic int_write
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_reset_level; device_reset == (host_reset_pin == reset_polarity_select); endproperty
    a_reset_level: assert property (p_reset_level) else $error("reset level wrong");
    property p_ready; host_memory_ready == aux_select_eight; endproperty
    a_ready: assert property (p_ready) else $error("ready differs from select eight");
    property p_pc_oe; !device_reset |-> port_c_oe == port_c_function_map; endproperty
    a_pc_oe: assert property (p_pc_oe) else $error("port c enable wrong");
    property p_pc_out; (!device_reset && port_c_function_map[1]) |-> port_c_out[1] == aux_select_nine; endproperty
    a_pc_out: assert property (p_pc_out) else $error("port c select output wrong");
    property p_open_drain;
        (!data_width_select && !device_reset) |-> (port_b_out & port_b_driver_style & port_b_function_map) == '0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");
    property p_rd_oe; $rose(int_read) |=> port_a_oe == '1; endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("port a not driven on read");
    property p_rd_wide; ($rose(int_read) && data_width_select) |=> port_b_oe == '1; endproperty
    a_rd_wide: assert property (p_rd_wide) else $error("port b not driven on wide read");
    property p_clear; device_reset |=> !int_read && !int_write && port_a_oe == '0; endproperty
    a_clear: assert property (p_clear) else $error("access active in reset");
endmodule

bind host_bus_adapt_config host_bus_monitor #(.PORT_W(PORT_W)) u_mon (
    .clk, .sys_rst, .data_width_select, .reset_polarity_select, .port_b_function_map,
    .port_b_driver_style, .port_c_function_map, .host_reset_pin, .port_a_oe, .port_b_out,
    .port_b_oe, .port_c_out, .port_c_oe, .aux_select_eight, .aux_select_nine,
    .host_memory_ready, .device_reset, .int_read, .int_write
);

// >>> bench/host_model.sv
// Host bus model: strobes, address and the shared data wires of ports A and B.
`timescale 1ns/100ps
module host_model (
    // Clock, strobe style and ready
    input wire logic clk,
    input wire logic style,
    input wire logic rdy,
    // Host drive toward the device
    output logic strobe_a,
    output logic strobe_b,
    output logic [15:0] addr,
    // Data wires
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    output logic [7:0] a_in,
    output logic [7:0] b_in
);
    logic [15:0] hval = 16'h0000;
    logic hen = 1'b0;
    initial begin
        strobe_a = 1'b1;
        strobe_b = 1'b1;
        addr = 16'h0000;
    end
    // A wire nobody drives shows the inverse of the device value, so no stale copy can pass.
    assign a_in = (a_oe & a_out) | (~a_oe & (hen ? hval[7:0] : ~a_out));
    assign b_in = (b_oe & b_out) | (~b_oe & (hen ? hval[15:8] : ~b_out));
    // One transfer; ok stays low when the device does not answer within the bound.
    task automatic xfer(input logic wr, input logic [15:0] ad, input logic [15:0] d, input int bound,
                        output logic [15:0] q, output logic ok);
        int n;
        q = 16'h0000;
        ok = 1'b0;
        @(posedge clk);
        addr <= ad;
        hval <= d;
        hen <= wr;
        strobe_a <= style ? !wr : wr;
        strobe_b <= style ? 1'b1 : !wr;
        for (n = 0; n < bound && ok !== 1'b1; n++) begin
            @(posedge clk);
            ok = wr ? rdy : (a_oe === 8'hff);
        end
        if (ok === 1'b1 && !wr) begin
            @(posedge clk);
            q = {b_out, a_out};
        end
        strobe_a <= 1'b1;
        strobe_b <= !style;
        hen <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the configurable host bus front end.
`timescale 1ns/100ps
`define CHECK_EQ(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, (e), (g)); end end
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic data_width_select = 1'b1;
    logic bus_mux_select = 1'b0;
    logic strobe_style_select = 1'b0;
    logic top_addr_pin_select = 1'b0;
    logic latch_strobe_polarity = 1'b0;
    logic reset_polarity_select = 1'b1;
    logic space_split_select = 1'b0;
    logic upper_addr_hold_select = 1'b1;
    logic [7:0] port_b_function_map = 8'h00;
    logic [7:0] port_b_driver_style = 8'h00;
    logic [2:0] port_c_function_map = 3'h6;
    logic [274:0] term_care;
    logic [274:0] term_match;
    logic [10:0] term_invert;
    logic host_reset_pin = 1'b0;
    logic latch_strobe_pin = 1'b0;
    logic prog_fetch_pin = 1'b1;
    logic top_addr_pin = 1'b0;
    logic strobe_a_pin, strobe_b_pin, ok;
    logic [15:0] addr_pin, int_write_data, q;
    logic [7:0] port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe, gpio_b_level;
    logic [2:0] pc_drv = 3'h0;
    logic [2:0] port_c_in, port_c_out, port_c_oe;
    logic aux_select_eight, aux_select_nine, aux_select_ten, host_memory_ready;
    logic [7:0] gpio_b_value = 8'h00;
    logic [7:0] gpio_b_drive = 8'h00;
    logic device_reset, int_prog_space, int_read, int_write;
    logic [19:0] int_addr;
    logic [15:0] int_read_data = 16'h0000;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_addr = 16'h0000;
    int wr_cnt = 0;
    int err_total = 0;
    int compares = 0;
    typedef struct packed {
        logic rp; logic [15:0] ad; logic tp; logic a16; logic er; logic ey; logic en; logic et;
    } row_type;
    row_type rows [4] = '{'{1'b0, 16'h3000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1},
        '{1'b0, 16'h2fff, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 16'h3fff, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
        '{1'b0, 16'h4000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1}};
    assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & pc_drv);
    host_bus_adapt_config u_dut (.clk, .sys_rst, .data_width_select, .bus_mux_select, .strobe_style_select,
        .top_addr_pin_select, .latch_strobe_polarity, .reset_polarity_select, .space_split_select,
        .upper_addr_hold_select, .port_b_function_map, .port_b_driver_style, .port_c_function_map,
        .term_care, .term_match, .term_invert, .host_reset_pin, .latch_strobe_pin, .strobe_a_pin,
        .strobe_b_pin, .prog_fetch_pin, .top_addr_pin, .addr_pin, .port_a_in, .port_a_out, .port_a_oe,
        .port_b_in, .port_b_out, .port_b_oe, .port_c_in, .port_c_out, .port_c_oe, .aux_select_eight,
        .aux_select_nine, .aux_select_ten, .host_memory_ready, .gpio_b_value, .gpio_b_drive,
        .gpio_b_level, .device_reset, .int_addr, .int_prog_space, .int_read, .int_write,
        .int_write_data, .int_read_data);
    host_model u_host (.clk, .style(strobe_style_select), .rdy(host_memory_ready), .strobe_a(strobe_a_pin),
        .strobe_b(strobe_b_pin), .addr(addr_pin), .a_out(port_a_out), .a_oe(port_a_oe), .b_out(port_b_out),
        .b_oe(port_b_oe), .a_in(port_a_in), .b_in(port_b_in));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (int_write === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_data <= int_write_data;
        end
        if (int_read === 1'b1) begin
            rd_addr <= int_addr[15:0];
        end
    end
    task automatic tally_and_finish();
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic go(input logic wr, input logic [15:0] ad, input logic [15:0] d);
        u_host.xfer(wr, ad, d, 8, q, ok);
        `CHECK_EQ("answer", 1'b1, ok)
        if (ok !== 1'b1) begin
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        // Own select and ready decode address bits 15..12 equal to 3; select nine is A16 and not
        // program space; select ten is the inverted chip-select input term.
        term_care = '0;
        term_match = '0;
        term_invert = '0;
        term_care[12 +: 4] = 4'hf;
        term_match[12 +: 4] = 4'h3;
        term_care[212 +: 4] = 4'hf;
        term_match[212 +: 4] = 4'h3;
        term_care[241] = 1'b1;
        term_match[241] = 1'b1;
        term_care[249] = 1'b1;
        term_care[273] = 1'b1;
        term_match[273] = 1'b1;
        term_invert[10] = 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk);
            host_reset_pin <= rows[i].rp;
            u_host.addr <= rows[i].ad;
            top_addr_pin <= rows[i].tp;
            pc_drv <= {2'b00, rows[i].a16};
            @(negedge clk);
            `CHECK_EQ("device_reset", rows[i].er, device_reset)
            `CHECK_EQ("ready", rows[i].ey, host_memory_ready)
            `CHECK_EQ("sel_nine", rows[i].en, aux_select_nine)
            `CHECK_EQ("sel_ten", rows[i].et, aux_select_ten)
            `CHECK_EQ("pc_oe", rows[i].er ? 3'h0 : 3'h6, port_c_oe)
            if (!rows[i].er) `CHECK_EQ("pc_out", {rows[i].et, rows[i].en}, port_c_out[2:1])
        end
        @(posedge clk);
        host_reset_pin <= 1'b0;
        int_read_data <= 16'hc35a;
        go(1'b0, 16'h3abc, 16'h0000);
        `CHECK_EQ("read16", 16'hc35a, q)
        `CHECK_EQ("rd_addr", 16'h3abc, rd_addr)
        go(1'b1, 16'h3001, 16'h9d27);
        `CHECK_EQ("wr16", 16'h9d27, wr_data)
        go(1'b1, 16'h3ffe, 16'h1e2f);
        `CHECK_EQ("wr16b", 16'h1e2f, wr_data)
        `CHECK_EQ("wr_cnt", 2, wr_cnt)
        u_host.xfer(1'b0, 16'h1234, 16'h0000, 5, q, ok);
        `CHECK_EQ("refused_rd", 1'b0, ok)
        u_host.xfer(1'b1, 16'h4000, 16'h5555, 2, q, ok);
        `CHECK_EQ("refused_wr", 2, wr_cnt)
        `CHECK_EQ("refused_rdy", 1'b0, ok)
        @(posedge clk);
        sys_rst <= 1'b1;
        data_width_select <= 1'b0;
        strobe_style_select <= 1'b1;
        top_addr_pin_select <= 1'b1;
        reset_polarity_select <= 1'b0;
        space_split_select <= 1'b1;
        port_b_function_map <= 8'hf0;
        port_b_driver_style <= 8'ha0;
        host_reset_pin <= 1'b1;
        top_addr_pin <= 1'b1;
        gpio_b_drive <= 8'hff;
        gpio_b_value <= 8'h5a;
        u_host.strobe_b <= 1'b0;
        u_host.addr <= 16'h3000;
        pc_drv <= 3'h1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        `CHECK_EQ("gpio_out", 4'h5, port_b_out[7:4])
        `CHECK_EQ("gpio_oe", 4'hf, port_b_oe[7:4])
        `CHECK_EQ("own_sel", 1'b1, port_b_out[0])
        `CHECK_EQ("space", 1'b0, aux_select_nine)
        `CHECK_EQ("csi_off", 1'b1, aux_select_ten)
        @(posedge clk);
        gpio_b_value <= 8'ha5;
        u_host.addr <= 16'h5000;
        prog_fetch_pin <= 1'b0;
        @(negedge clk);
        `CHECK_EQ("gpio_out2", 4'h0, port_b_out[7:4])
        `CHECK_EQ("gpio_oe2", 4'h5, port_b_oe[7:4])
        `CHECK_EQ("gpio_level", 4'ha, gpio_b_level[7:4])
        `CHECK_EQ("own_sel2", 1'b0, port_b_out[0])
        `CHECK_EQ("space2", 1'b1, aux_select_nine)
        `CHECK_EQ("prog_space", 1'b1, int_prog_space)
        @(posedge clk);
        host_reset_pin <= 1'b0;
        @(negedge clk);
        `CHECK_EQ("reset_low", 1'b1, device_reset)
        @(posedge clk);
        host_reset_pin <= 1'b1;
        int_read_data <= 16'h7e81;
        go(1'b0, 16'h3456, 16'h0000);
        `CHECK_EQ("read8", 8'h81, q[7:0])
        go(1'b1, 16'h3002, 16'h00b4);
        `CHECK_EQ("wr8", 8'hb4, wr_data[7:0])
        // Multiplexed bus with an active-low latch strobe and latched upper address.
        @(posedge clk);
        sys_rst <= 1'b1;
        bus_mux_select <= 1'b1;
        latch_strobe_polarity <= 1'b1;
        upper_addr_hold_select <= 1'b0;
        latch_strobe_pin <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        latch_strobe_pin <= 1'b0;
        u_host.addr <= 16'h3000;
        u_host.hval <= 16'h0077;
        u_host.hen <= 1'b1;
        @(posedge clk);
        latch_strobe_pin <= 1'b1;
        u_host.hval <= 16'h00ff;
        top_addr_pin <= 1'b0;
        pc_drv <= 3'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHECK_EQ("mux_addr", 20'h93077, int_addr)
        `CHECK_EQ("held_a16", 1'b1, aux_select_nine)
        tally_and_finish();
    end
endmodule

// >>> design/decode_array.sv
// Programmable AND-array address decoder producing chip-select terms.
`timescale 1ns/100ps
module decode_array #(
    parameter int IN_W = 25,
    parameter int OUT_W = 11
) (
    // Logic terms from the host bus
    input wire logic [IN_W-1:0] term_in,
    // Programming of each product term
    input wire logic [OUT_W*IN_W-1:0] term_care,
    input wire logic [OUT_W*IN_W-1:0] term_match,
    input wire logic [OUT_W-1:0] term_invert,
    // Decoded selects
    output logic [OUT_W-1:0] select_out
);

    // A term is true when every cared-for input equals its programmed value.
    function automatic logic term_hit(input logic [IN_W-1:0] val, input logic [IN_W-1:0] care,
                                      input logic [IN_W-1:0] match);
        term_hit = ((val ^ match) & care) == '0;
    endfunction

    genvar g;
    generate
        for (g = 0; g < OUT_W; g = g + 1) begin : g_term
            assign select_out[g] = term_invert[g] ^ term_hit(term_in, term_care[g*IN_W +: IN_W],
                                                              term_match[g*IN_W +: IN_W]);
        end
    endgenerate

endmodule

// >>> design/host_bus_adapt_config.sv
// Configurable host bus front end: strobes, address latch, data ports, port pin functions and decoder.
`timescale 1ns/100ps
`include "host_bus_cfg.svh"

module host_bus_adapt_config #(
    parameter int PORT_W = `PORT_W,
    parameter int NUM_CS = `NUM_CS,
    parameter int DEC_IN_W = `DEC_IN_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Non-volatile configuration bits
    input wire logic data_width_select,
    input wire logic bus_mux_select,
    input wire logic strobe_style_select,
    input wire logic top_addr_pin_select,
    input wire logic latch_strobe_polarity,
    input wire logic reset_polarity_select,
    input wire logic space_split_select,
    input wire logic upper_addr_hold_select,
    input wire logic [PORT_W-1:0] port_b_function_map,
    input wire logic [PORT_W-1:0] port_b_driver_style,
    input wire logic [`PORT_C_W-1:0] port_c_function_map,
    // Decode array programming
    input wire logic [NUM_CS*DEC_IN_W-1:0] term_care,
    input wire logic [NUM_CS*DEC_IN_W-1:0] term_match,
    input wire logic [NUM_CS-1:0] term_invert,
    // Host control inputs
    input wire logic host_reset_pin,
    input wire logic latch_strobe_pin,
    input wire logic strobe_a_pin,
    input wire logic strobe_b_pin,
    input wire logic prog_fetch_pin,
    input wire logic top_addr_pin,
    // Host address inputs: all 16 in separate address mode, bits 15..8 in 8-bit multiplexed mode
    input wire logic [15:0] addr_pin,
    // Port A
    input wire logic [PORT_W-1:0] port_a_in,
    output logic [PORT_W-1:0] port_a_out,
    output logic [PORT_W-1:0] port_a_oe,
    // Port B
    input wire logic [PORT_W-1:0] port_b_in,
    output logic [PORT_W-1:0] port_b_out,
    output logic [PORT_W-1:0] port_b_oe,
    // Port C
    input wire logic [`PORT_C_W-1:0] port_c_in,
    output logic [`PORT_C_W-1:0] port_c_out,
    output logic [`PORT_C_W-1:0] port_c_oe,
    // Decoder outputs toward the host
    output logic aux_select_eight,
    output logic aux_select_nine,
    output logic aux_select_ten,
    output logic host_memory_ready,
    // General I/O on Port B
    input wire logic [PORT_W-1:0] gpio_b_value,
    input wire logic [PORT_W-1:0] gpio_b_drive,
    output logic [PORT_W-1:0] gpio_b_level,
    // Internal access side toward the memory and port blocks
    output logic device_reset,
    output logic [`ADDR_W-1:0] int_addr,
    output logic int_prog_space,
    output logic int_read,
    output logic int_write,
    output logic [`WIDE_W-1:0] int_write_data,
    input wire logic [`WIDE_W-1:0] int_read_data
);

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain pins only pull low; push-pull pins drive both levels.

    function automatic logic [1:0] pin_drive(input logic value, input logic enable, input logic open_drain);
        if (open_drain) begin
            pin_drive = {1'b0, enable & ~value};
        end else begin
            pin_drive = {value, enable};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset and configuration capture.

    logic host_reset_level;
    logic in_reset;
    logic wide_r;
    logic mux_r;
    logic style_r;
    logic top_r;
    logic latch_pol_r;
    logic split_r;
    logic hold_r;
    logic [PORT_W-1:0] b_func_r;
    logic [PORT_W-1:0] b_drv_r;
    logic [`PORT_C_W-1:0] c_func_r;

    assign host_reset_level = reset_polarity_select ? host_reset_pin : ~host_reset_pin;
    assign in_reset = sys_rst | host_reset_level;
    assign device_reset = in_reset;

    // Settings are taken while reset is held, so they stay fixed during operation.
    always_ff @(posedge clk) begin
        if (in_reset) begin
            wide_r <= data_width_select;
            mux_r <= bus_mux_select;
            style_r <= strobe_style_select;
            top_r <= top_addr_pin_select;
            latch_pol_r <= latch_strobe_polarity;
            split_r <= space_split_select;
            hold_r <= upper_addr_hold_select;
            b_func_r <= port_b_function_map;
            b_drv_r <= port_b_driver_style;
            c_func_r <= port_c_function_map;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe decoding.

    logic rd_act;
    logic wr_act;
    logic latch_act;

    always_comb begin
        if (style_r) begin
            rd_act = strobe_b_pin & strobe_a_pin;
            wr_act = strobe_b_pin & ~strobe_a_pin;
        end else begin
            rd_act = ~strobe_a_pin;
            wr_act = ~strobe_b_pin;
        end
    end

    assign latch_act = latch_pol_r ? ~latch_strobe_pin : latch_strobe_pin;

    ////////////////////////////////////////////////////////////////////////////////
    // Address path.

    logic [15:0] low_live;
    logic [3:0] upper_live;
    logic [15:0] low_r;
    logic [3:0] upper_r;
    logic [15:0] low_eff;
    logic [3:0] upper_eff;
    logic [`ADDR_W-1:0] addr_eff;
    logic csi_term;
    logic space_term;

    always_comb begin
        if (mux_r & wide_r) begin
            low_live = {port_b_in, port_a_in};
        end else if (mux_r) begin
            low_live = {addr_pin[15:8], port_a_in};
        end else begin
            low_live = addr_pin;
        end
    end

    // Port C inputs supply A16-A18; the shared pin is A19 only when chosen.
    always_comb begin
        upper_live[2:0] = port_c_in & ~c_func_r;
        upper_live[3] = top_r & top_addr_pin;
    end

    assign csi_term = ~top_r & top_addr_pin;
    assign space_term = split_r & prog_fetch_pin;

    // Low address is held after the latch strobe in multiplexed mode.
    always_ff @(posedge clk) begin
        if (in_reset) begin
            low_r <= `RST_WIDE;
        end else if (latch_act) begin
            low_r <= low_live;
        end
    end

    always_ff @(posedge clk) begin
        if (in_reset) begin
            upper_r <= `RST_UPPER;
        end else if (latch_act) begin
            upper_r <= upper_live;
        end
    end

    // The latches behave as transparent while the strobe is active.
    assign low_eff = (mux_r & ~latch_act) ? low_r : low_live;
    assign upper_eff = (~hold_r & ~latch_act) ? upper_r : upper_live;
    assign addr_eff = {upper_eff, low_eff};

    ////////////////////////////////////////////////////////////////////////////////
    // Decode array.

    logic [DEC_IN_W-1:0] dec_terms;
    logic [NUM_CS-1:0] cs_vec;

    always_comb begin
        dec_terms = '0;
        dec_terms[`DEC_ADDR_LSB +: `ADDR_W] = addr_eff;
        dec_terms[`DEC_RD_POS] = rd_act;
        dec_terms[`DEC_WR_POS] = wr_act;
        dec_terms[`DEC_LATCH_POS] = latch_strobe_pin;
        dec_terms[`DEC_CSI_POS] = csi_term;
        dec_terms[`DEC_SPACE_POS] = space_term;
    end

    decode_array #(
        .IN_W(DEC_IN_W),
        .OUT_W(NUM_CS)
    ) u_decode (
        .term_in(dec_terms),
        .term_care(term_care),
        .term_match(term_match),
        .term_invert(term_invert),
        .select_out(cs_vec)
    );

    assign aux_select_eight = cs_vec[`CS_AUX_LSB];
    assign aux_select_nine = cs_vec[`CS_AUX_LSB+1];
    assign aux_select_ten = cs_vec[`CS_AUX_LSB+2];
    assign host_memory_ready = cs_vec[`CS_READY_POS];

    ////////////////////////////////////////////////////////////////////////////////
    // Access sequencing.

    host_bus_pkg::access_state_type state_r;
    host_bus_pkg::access_state_type state_nxt;
    logic own_sel;

    assign own_sel = cs_vec[`CS_OWN_POS];

    always_comb begin
        case (state_r)
            host_bus_pkg::ST_IDLE: begin
                if (mux_r & latch_act) begin
                    state_nxt = host_bus_pkg::ST_ADDR;
                end else if (rd_act & own_sel) begin
                    state_nxt = host_bus_pkg::ST_READ;
                end else if (wr_act & own_sel) begin
                    state_nxt = host_bus_pkg::ST_WRITE;
                end else begin
                    state_nxt = host_bus_pkg::ST_IDLE;
                end
            end
            host_bus_pkg::ST_ADDR: begin
                if (latch_act) begin
                    state_nxt = host_bus_pkg::ST_ADDR;
                end else begin
                    state_nxt = host_bus_pkg::ST_IDLE;
                end
            end
            host_bus_pkg::ST_READ: begin
                if (rd_act) begin
                    state_nxt = host_bus_pkg::ST_READ;
                end else begin
                    state_nxt = host_bus_pkg::ST_IDLE;
                end
            end
            host_bus_pkg::ST_WRITE: begin
                if (wr_act) begin
                    state_nxt = host_bus_pkg::ST_WRITE;
                end else begin
                    state_nxt = host_bus_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = host_bus_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (in_reset) begin
            state_r <= host_bus_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Internal access outputs.

    logic [`ADDR_W-1:0] addr_r;
    logic space_r;
    logic read_r;
    logic write_r;
    logic [`WIDE_W-1:0] wdata_r;
    logic [`WIDE_W-1:0] rdata_r;
    logic [`WIDE_W-1:0] host_data;

    // In 8-bit mode only Port A carries data.
    assign host_data = wide_r ? {port_b_in, port_a_in} : {8'h00, port_a_in};

    always_ff @(posedge clk) begin
        if (in_reset) begin
            addr_r <= `RST_ADDR;
            space_r <= 1'b0;
        end else if (state_r == host_bus_pkg::ST_IDLE) begin
            addr_r <= addr_eff;
            space_r <= space_term;
        end
    end

    // One write pulse per host write, with the data present at the strobe.
    always_ff @(posedge clk) begin
        if (in_reset) begin
            write_r <= 1'b0;
            wdata_r <= `RST_WIDE;
        end else begin
            write_r <= (state_r == host_bus_pkg::ST_IDLE) & (state_nxt == host_bus_pkg::ST_WRITE);
            if (state_nxt == host_bus_pkg::ST_WRITE) begin
                wdata_r <= host_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (in_reset) begin
            read_r <= 1'b0;
            rdata_r <= `RST_WIDE;
        end else begin
            read_r <= state_nxt == host_bus_pkg::ST_READ;
            if (state_r == host_bus_pkg::ST_READ) begin
                rdata_r <= int_read_data;
            end
        end
    end

    assign int_addr = addr_r;
    assign int_prog_space = space_r;
    assign int_read = read_r;
    assign int_write = write_r;
    assign int_write_data = wdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    logic drive_data;
    logic [1:0] b_pin [PORT_W];

    // Data lanes turn on only while the device answers a read.
    assign drive_data = (state_r == host_bus_pkg::ST_READ) & read_r & ~in_reset;

    assign port_a_out = rdata_r[PORT_W-1:0];
    assign port_a_oe = {PORT_W{drive_data}};

    genvar gb;
    generate
        for (gb = 0; gb < PORT_W; gb = gb + 1) begin : g_port_b
            always_comb begin
                if (wide_r) begin
                    b_pin[gb] = {rdata_r[PORT_W+gb], drive_data};
                end else if (b_func_r[gb]) begin
                    b_pin[gb] = pin_drive(gpio_b_value[gb], gpio_b_drive[gb] & ~in_reset,
                                          b_drv_r[gb]);
                end else if (gb < `CS_AUX_LSB) begin
                    b_pin[gb] = pin_drive(cs_vec[gb], ~in_reset, b_drv_r[gb]);
                end else begin
                    b_pin[gb] = 2'b00;
                end
            end
            assign port_b_out[gb] = b_pin[gb][1];
            assign port_b_oe[gb] = b_pin[gb][0];
        end
    endgenerate

    assign gpio_b_level = port_b_in;

    genvar gc;
    generate
        for (gc = 0; gc < `PORT_C_W; gc = gc + 1) begin : g_port_c
            assign port_c_out[gc] = cs_vec[`CS_AUX_LSB+gc];
            assign port_c_oe[gc] = c_func_r[gc] & ~in_reset;
        end
    endgenerate

endmodule

// >>> shared/host_bus_cfg.svh
// Constants for the configurable host bus front end: widths, field positions and reset values.
`ifndef HOST_BUS_CFG_SVH
`define HOST_BUS_CFG_SVH

// Port and bus widths.
`define PORT_W 8
`define WIDE_W 16
`define ADDR_W 20
`define PORT_C_W 3
`define NUM_CS 11

// Decode array input vector layout.
`define DEC_IN_W 25
`define DEC_ADDR_LSB 0
`define DEC_RD_POS 20
`define DEC_WR_POS 21
`define DEC_LATCH_POS 22
`define DEC_CSI_POS 23
`define DEC_SPACE_POS 24

// Decode output positions.
`define CS_OWN_POS 0
`define CS_AUX_LSB 8
`define CS_READY_POS 8

// Reset values.
`define RST_PORT 8'h00
`define RST_WIDE 16'h0000
`define RST_ADDR 20'h00000
`define RST_UPPER 4'h0
`define RST_PORT_C 3'h0

`endif

// >>> shared/host_bus_pkg.sv
// Types shared by the host bus front end.
package host_bus_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ADDR  = 4'b0010,
        ST_READ  = 4'b0100,
        ST_WRITE = 4'b1000
    } access_state_type;

endpackage
